// >>> design/endpoint_cfg_pkg.sv
package endpoint_cfg_pkg;

    // Register byte offsets
    localparam logic [15:0] DEV_IDENTITY_OFS   = 16'h0000;
    localparam logic [15:0] ASM_IDENTITY_OFS   = 16'h0008;
    localparam logic [15:0] ASM_INFO_OFS       = 16'h000c;
    localparam logic [15:0] ELEM_FEATURES_OFS  = 16'h0010;
    localparam logic [15:0] THRESHOLDS_OFS     = 16'h0040;
    localparam logic [15:0] FLOW_CTRL_OFS      = 16'h0044;
    localparam logic [15:0] IRQ_STATUS_OFS     = 16'h0048;
    localparam logic [15:0] IRQ_MASK_OFS       = 16'h004c;
    localparam logic [15:0] LINK_TIMEOUT_OFS   = 16'h0120;
    localparam logic [15:0] RESP_TIMEOUT_OFS   = 16'h0124;
    localparam logic [15:0] GEN_CTRL_OFS       = 16'h013c;

    // Extended feature block placement and sizes
    localparam logic [15:0] SERIAL_BLOCK_OFS   = 16'h0100;
    localparam logic [15:0] LANE_BLOCK_OFS     = 16'h0400;
    localparam logic [15:0] SERIAL_BLOCK_SIZE  = 16'h0100;
    localparam logic [15:0] LANE_BLOCK_SIZE    = 16'h0400;
    localparam logic [15:0] LINK_TIMEOUT_REL   = 16'h0020;
    localparam logic [15:0] RESP_TIMEOUT_REL   = 16'h0024;
    localparam logic [15:0] GEN_CTRL_REL       = 16'h003c;

    // Field positions
    localparam int TIMEOUT_LSB        = 8;
    localparam int GEN_HOST_BIT       = 31;
    localparam int GEN_REQ_EN_BIT     = 30;
    localparam int GEN_LOCATED_BIT    = 29;
    localparam int FEAT_BRIDGE_BIT    = 31;
    localparam int FEAT_MEMORY_BIT    = 30;
    localparam int FEAT_PROC_BIT      = 29;
    localparam int FEAT_EXT_BIT       = 3;
    localparam int FLOW_TX_EN_BIT     = 0;
    localparam int FLOW_TX_ACT_BIT    = 1;
    localparam int FLOW_ALLOWED_LSB   = 4;
    localparam int THR_HIGH_LSB       = 0;
    localparam int THR_MED_LSB        = 8;
    localparam int THR_LOW_LSB        = 16;
    localparam int IRQ_LINK_TO_BIT    = 0;
    localparam int IRQ_HELD_BIT       = 1;
    localparam int IRQ_FALLBACK_BIT   = 2;
    localparam int IRQ_W              = 3;

    // Reset values
    localparam logic [23:0] LINK_TIMEOUT_RST   = 24'hffffff;
    localparam logic [23:0] RESP_TIMEOUT_RST   = 24'hffffff;
    localparam logic        GEN_HOST_RST       = 1'h1;
    localparam logic        GEN_REQ_EN_RST     = 1'h1;
    localparam logic        GEN_LOCATED_RST    = 1'h1;
    localparam logic        FLOW_TX_EN_RST     = 1'h1;
    localparam logic [7:0]  THR_HIGH_RST       = 8'h01;
    localparam logic [7:0]  THR_MED_RST        = 8'h02;
    localparam logic [7:0]  THR_LOW_RST        = 8'h03;

    // Link timeout scaling: full-scale value gives the longest timeout
    localparam int unsigned CLK_PERIOD_NS          = 10;
    localparam int unsigned NS_PER_MS              = 1_000_000;
    localparam int unsigned LINK_TIMEOUT_MAX_MS    = 4500;
    localparam int unsigned LINK_TIMEOUT_FULL      = 24'hffffff;
    localparam int unsigned LINK_TICK_CYCLES       =
        LINK_TIMEOUT_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS) / LINK_TIMEOUT_FULL;

    typedef enum logic [1:0] {
        FUNC_BRIDGE,
        FUNC_MEMORY,
        FUNC_PROCESSOR
    } elem_func_e;

    typedef struct packed {
        logic       valid;
        logic [1:0] prio;
    } pkt_req_s;

    typedef struct packed {
        logic       grant;
        logic       hold;
    } pkt_ans_s;

endpackage

// >>> design/link_symbol_timer.sv
`timescale 1ns/10ps
`default_nettype none

module link_symbol_timer #(
    parameter int unsigned TICK_CYCLES = endpoint_cfg_pkg::LINK_TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic [23:0] interval,
    output logic             expired_q
);

    localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

    logic          running_q;
    logic [TW-1:0] pre_q;
    logic [23:0]   units_q;
    wire           tick    = running_q && (pre_q == TW'(TICK_CYCLES - 1));
    wire           reached = tick && (units_q >= interval);

    // A new symbol restarts the window; an acknowledge ends it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            running_q <= 1'b0;
            pre_q     <= '0;
            units_q   <= '0;
            expired_q <= 1'b0;
        end else begin
            expired_q <= reached;
            if (start) begin
                running_q <= 1'b1;
                pre_q     <= '0;
                units_q   <= '0;
            end else if (stop || reached) begin
                running_q <= 1'b0;
            end else if (running_q) begin
                pre_q <= tick ? '0 : pre_q + 1'b1;
                if (tick)
                    units_q <= units_q + 24'h000001;
            end
        end
    end

endmodule

`default_nettype wire

// >>> design/endpoint_flow_gate_and_config_regs.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - At or above its own threshold and those of all higher priorities, a priority may send.
// - Priority 3 sends until the partner's free count reaches zero.
// - Priority 2 needs at least the high-priority threshold free.
// - Priority 1 needs at least the medium-priority threshold free.
// - Priority 0 needs at least the lowest-priority threshold free.
// - Thresholds gate only under transmitter-controlled flow control.
// - Device identity is fixed and ignores writes.
// - Assembly fields are fixed at build and affect nothing else.
// - Features report bridge, memory or processor; memory by default.
// - Serial port block spans 0x100 bytes, lane block 0x400 bytes.
// - Outstanding link symbols are timed; timeout scales linearly up to ~4.5 s.
// - Requests may be issued only while the request-enable bit is set; the bit only drives request_enable_q, and packet grants ignore it.
// - Host and located bits are stored and read back only.
// - Without partner support, fall back to ungated receiver-controlled flow.
module endpoint_flow_gate_and_config_regs #(
    parameter int                           ADDR_W      = 16,
    parameter int                           FREE_W      = 8,
    parameter int unsigned                  TICK_CYCLES = endpoint_cfg_pkg::LINK_TICK_CYCLES,
    parameter logic [15:0]                  DEVICE_ID   = 16'h1234, // Arbitrary value
    parameter logic [15:0]                  VENDOR_ID   = 16'h0abc, // Arbitrary value
    parameter logic [15:0]                  ASM_ID      = 16'h0000,
    parameter logic [15:0]                  ASM_VENDOR  = 16'h0000,
    parameter logic [15:0]                  ASM_REV     = 16'h0000,
    parameter endpoint_cfg_pkg::elem_func_e ELEM_FUNC   = endpoint_cfg_pkg::FUNC_MEMORY,
    parameter logic [15:0]                  SERIAL_OFS  = endpoint_cfg_pkg::SERIAL_BLOCK_OFS,
    parameter logic [15:0]                  LANE_OFS    = endpoint_cfg_pkg::LANE_BLOCK_OFS,
    parameter logic [15:0]                  SERIAL_BID  = 16'h0001,
    parameter logic [15:0]                  LANE_BID    = 16'h000d
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    // Register port
    input  wire logic [ADDR_W-1:0]          addr,
    input  wire logic [31:0]                wr_data,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output logic [31:0]                     rd_data_q,
    // Link partner state
    input  wire logic [FREE_W-1:0]          partner_free,
    input  wire logic                       partner_tx_ctrl_ok,
    // Link control symbols
    input  wire logic                       symbol_sent,
    input  wire logic                       symbol_acked,
    output logic                            link_recover_q,
    // Packet start request and decision
    input  wire endpoint_cfg_pkg::pkt_req_s pkt_req,
    output endpoint_cfg_pkg::pkt_ans_s      pkt_ans_q,
    output logic [3:0]                      prio_allowed_q,
    // Endpoint controls
    output logic                            request_enable_q,
    output logic [23:0]                     response_timeout_q,
    output logic                            irq_q
);

    localparam int IRQ_W_L = endpoint_cfg_pkg::IRQ_W;

    // Software-visible state
    logic [23:0]                 link_timeout_q;
    logic                        host_q;
    logic                        located_q;
    logic                        tx_ctrl_en_q;
    logic [7:0]                  thr_high_q;
    logic [7:0]                  thr_med_q;
    logic [7:0]                  thr_low_q;
    logic [IRQ_W_L-1:0]          irq_status_q;
    logic [IRQ_W_L-1:0]          irq_mask_q;
    logic                        tx_ctrl_act_q;

    // Address decode
    wire [15:0] a16 = 16'(addr);
    wire hit_dev_id   = (a16 == endpoint_cfg_pkg::DEV_IDENTITY_OFS);
    wire hit_asm_id   = (a16 == endpoint_cfg_pkg::ASM_IDENTITY_OFS);
    wire hit_asm_info = (a16 == endpoint_cfg_pkg::ASM_INFO_OFS);
    wire hit_features = (a16 == endpoint_cfg_pkg::ELEM_FEATURES_OFS);
    wire hit_thr      = (a16 == endpoint_cfg_pkg::THRESHOLDS_OFS);
    wire hit_flow     = (a16 == endpoint_cfg_pkg::FLOW_CTRL_OFS);
    wire hit_irq_st   = (a16 == endpoint_cfg_pkg::IRQ_STATUS_OFS);
    wire hit_irq_mask = (a16 == endpoint_cfg_pkg::IRQ_MASK_OFS);
    // The physical-layer registers live inside the serial port block
    wire hit_ser_hdr  = (a16 == SERIAL_OFS);
    wire hit_lane_hdr = (a16 == LANE_OFS);
    wire hit_link_to  = (a16 == SERIAL_OFS + endpoint_cfg_pkg::LINK_TIMEOUT_REL);
    wire hit_resp_to  = (a16 == SERIAL_OFS + endpoint_cfg_pkg::RESP_TIMEOUT_REL);
    wire hit_gen_ctrl = (a16 == SERIAL_OFS + endpoint_cfg_pkg::GEN_CTRL_REL);

    wire wr_thr      = wr_en && hit_thr;
    wire wr_flow     = wr_en && hit_flow;
    wire wr_irq_st   = wr_en && hit_irq_st;
    wire wr_irq_mask = wr_en && hit_irq_mask;
    wire wr_link_to  = wr_en && hit_link_to;
    wire wr_resp_to  = wr_en && hit_resp_to;
    wire wr_gen_ctrl = wr_en && hit_gen_ctrl;

    // Fixed capability words; writes to them have no decode at all
    wire [31:0] dev_id_word   = {DEVICE_ID, VENDOR_ID};
    wire [31:0] asm_id_word   = {ASM_ID, ASM_VENDOR};
    // Low half points at the first extended feature block
    wire [31:0] asm_info_word = {ASM_REV, SERIAL_OFS};

    logic [31:0] features_word;
    always_comb begin
        features_word = 32'h00000000;
        features_word[endpoint_cfg_pkg::FEAT_EXT_BIT] = 1'b1;
        unique case (ELEM_FUNC)
            endpoint_cfg_pkg::FUNC_BRIDGE:    features_word[endpoint_cfg_pkg::FEAT_BRIDGE_BIT] = 1'b1;
            endpoint_cfg_pkg::FUNC_MEMORY:    features_word[endpoint_cfg_pkg::FEAT_MEMORY_BIT] = 1'b1;
            endpoint_cfg_pkg::FUNC_PROCESSOR: features_word[endpoint_cfg_pkg::FEAT_PROC_BIT] = 1'b1;
            default:                          features_word[endpoint_cfg_pkg::FEAT_MEMORY_BIT] = 1'b1;
        endcase
    end

    // Block headers chain serial -> lane -> end of list
    wire [31:0] ser_hdr_word  = {LANE_OFS, SERIAL_BID};
    wire [31:0] lane_hdr_word = {16'h0000, LANE_BID};

    wire [31:0] link_to_word  = {link_timeout_q, 8'h00};
    wire [31:0] resp_to_word  = {response_timeout_q, 8'h00};

    logic [31:0] gen_ctrl_word;
    logic [31:0] flow_word;
    logic [31:0] thr_word;
    always_comb begin
        gen_ctrl_word = 32'h00000000;
        gen_ctrl_word[endpoint_cfg_pkg::GEN_HOST_BIT]    = host_q;
        gen_ctrl_word[endpoint_cfg_pkg::GEN_REQ_EN_BIT]  = request_enable_q;
        gen_ctrl_word[endpoint_cfg_pkg::GEN_LOCATED_BIT] = located_q;
        flow_word = 32'h00000000;
        flow_word[endpoint_cfg_pkg::FLOW_TX_EN_BIT]  = tx_ctrl_en_q;
        flow_word[endpoint_cfg_pkg::FLOW_TX_ACT_BIT] = tx_ctrl_act_q;
        flow_word[endpoint_cfg_pkg::FLOW_ALLOWED_LSB +: 4] = prio_allowed_q;
        thr_word = 32'h00000000;
        thr_word[endpoint_cfg_pkg::THR_HIGH_LSB +: 8] = thr_high_q;
        thr_word[endpoint_cfg_pkg::THR_MED_LSB +: 8]  = thr_med_q;
        thr_word[endpoint_cfg_pkg::THR_LOW_LSB +: 8]  = thr_low_q;
    end

    // Unmapped addresses read as zero
    wire [31:0] rd_mux =
        hit_dev_id   ? dev_id_word :
        hit_asm_id   ? asm_id_word :
        hit_asm_info ? asm_info_word :
        hit_features ? features_word :
        hit_thr      ? thr_word :
        hit_flow     ? flow_word :
        hit_irq_st   ? 32'(irq_status_q) :
        hit_irq_mask ? 32'(irq_mask_q) :
        hit_link_to  ? link_to_word :
        hit_resp_to  ? resp_to_word :
        hit_gen_ctrl ? gen_ctrl_word :
        hit_ser_hdr  ? ser_hdr_word :
        hit_lane_hdr ? lane_hdr_word : 32'h00000000;

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            rd_data_q <= 32'h00000000;
        else
            rd_data_q <= rd_en ? rd_mux : 32'h00000000;
    end

    // Writable control registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link_timeout_q     <= endpoint_cfg_pkg::LINK_TIMEOUT_RST;
            response_timeout_q <= endpoint_cfg_pkg::RESP_TIMEOUT_RST;
            host_q             <= endpoint_cfg_pkg::GEN_HOST_RST;
            request_enable_q   <= endpoint_cfg_pkg::GEN_REQ_EN_RST;
            located_q          <= endpoint_cfg_pkg::GEN_LOCATED_RST;
        end else begin
            if (wr_link_to)
                link_timeout_q <= wr_data[endpoint_cfg_pkg::TIMEOUT_LSB +: 24];
            if (wr_resp_to)
                response_timeout_q <= wr_data[endpoint_cfg_pkg::TIMEOUT_LSB +: 24];
            if (wr_gen_ctrl) begin
                host_q           <= wr_data[endpoint_cfg_pkg::GEN_HOST_BIT];
                request_enable_q <= wr_data[endpoint_cfg_pkg::GEN_REQ_EN_BIT];
                located_q        <= wr_data[endpoint_cfg_pkg::GEN_LOCATED_BIT];
            end
        end
    end

    // Threshold and flow control registers; ordering is left to software
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            thr_high_q   <= endpoint_cfg_pkg::THR_HIGH_RST;
            thr_med_q    <= endpoint_cfg_pkg::THR_MED_RST;
            thr_low_q    <= endpoint_cfg_pkg::THR_LOW_RST;
            tx_ctrl_en_q <= endpoint_cfg_pkg::FLOW_TX_EN_RST;
        end else begin
            if (wr_thr) begin
                thr_high_q <= wr_data[endpoint_cfg_pkg::THR_HIGH_LSB +: 8];
                thr_med_q  <= wr_data[endpoint_cfg_pkg::THR_MED_LSB +: 8];
                thr_low_q  <= wr_data[endpoint_cfg_pkg::THR_LOW_LSB +: 8];
            end
            if (wr_flow)
                tx_ctrl_en_q <= wr_data[endpoint_cfg_pkg::FLOW_TX_EN_BIT];
        end
    end

    // Flow gating
    // Transmitter control needs both local enable and partner support
    wire        tx_ctrl_act_d = tx_ctrl_en_q && partner_tx_ctrl_ok;
    wire [7:0]  free8         = 8'(partner_free);
    wire [3:0]  thr_ok;

    assign thr_ok[3] = (free8 != 8'h00);
    assign thr_ok[2] = (free8 >= thr_high_q);
    assign thr_ok[1] = (free8 >= thr_med_q);
    assign thr_ok[0] = (free8 >= thr_low_q);

    // A priority passes only if it and every higher priority pass, so a
    // misordered threshold set cannot open a lower priority alone
    wire [3:0] cum_ok;
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_prio
            if (gp == 3) begin : g_top
                assign cum_ok[gp] = thr_ok[gp];
            end else begin : g_low
                assign cum_ok[gp] = thr_ok[gp] && cum_ok[gp+1];
            end
        end
    endgenerate

    // Receiver-controlled operation sends everything and relies on retry
    wire [3:0] allowed_d = tx_ctrl_act_d ? cum_ok : 4'hf;

    // Decision uses the free count present at the packet start itself
    wire pkt_ok = allowed_d[pkt_req.prio];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prio_allowed_q  <= 4'hf;
            tx_ctrl_act_q   <= 1'b0;
            pkt_ans_q       <= '0;
        end else begin
            prio_allowed_q  <= allowed_d;
            tx_ctrl_act_q   <= tx_ctrl_act_d;
            pkt_ans_q.grant <= pkt_req.valid && pkt_ok;
            pkt_ans_q.hold  <= pkt_req.valid && !pkt_ok;
        end
    end

    // Link symbol timeout
    logic link_expired;

    link_symbol_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_link_timer (
        .clk       (clk),
        .resetn    (resetn),
        .start     (symbol_sent),
        .stop      (symbol_acked),
        .interval  (link_timeout_q),
        .expired_q (link_expired)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            link_recover_q <= 1'b0;
        else
            link_recover_q <= link_expired;
    end

    // Interrupts
    wire [IRQ_W_L-1:0] irq_events;
    assign irq_events[endpoint_cfg_pkg::IRQ_LINK_TO_BIT]  = link_expired;
    assign irq_events[endpoint_cfg_pkg::IRQ_HELD_BIT]     = pkt_req.valid && !pkt_ok;
    assign irq_events[endpoint_cfg_pkg::IRQ_FALLBACK_BIT] = tx_ctrl_act_q && !tx_ctrl_act_d;

    // Set wins over a write-one-to-clear in the same cycle
    wire [IRQ_W_L-1:0] irq_clear  = wr_irq_st ? wr_data[IRQ_W_L-1:0] : '0;
    wire [IRQ_W_L-1:0] irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
    wire               irq_d      = |(irq_status_d & irq_mask_q);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_status_q <= '0;
            irq_mask_q   <= '0;
            irq_q        <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            if (wr_irq_mask)
                irq_mask_q <= wr_data[IRQ_W_L-1:0];
            irq_q <= irq_d;
        end
    end

endmodule

`default_nettype wire

// >>> test/endpoint_flow_gate_chk.sv
`timescale 1ns/10ps
`default_nettype none
module endpoint_flow_gate_chk #(
    parameter int          ADDR_W    = 16,
    parameter int          FREE_W    = 8,
    parameter logic [15:0] DEVICE_ID = 16'h0000,
    parameter logic [15:0] VENDOR_ID = 16'h0000
) (
    input wire logic                       clk,
    input wire logic                       resetn,
    input wire logic [ADDR_W-1:0]          addr,
    input wire logic [31:0]                wr_data,
    input wire logic                       wr_en,
    input wire logic                       rd_en,
    input wire logic [31:0]                rd_data_q,
    input wire logic [FREE_W-1:0]          partner_free,
    input wire logic                       partner_tx_ctrl_ok,
    input wire logic                       symbol_sent,
    input wire logic                       symbol_acked,
    input wire logic                       link_recover_q,
    input wire endpoint_cfg_pkg::pkt_req_s pkt_req,
    input wire endpoint_cfg_pkg::pkt_ans_s pkt_ans_q,
    input wire logic [3:0]                 prio_allowed_q,
    input wire logic                       request_enable_q
);
    logic [23:0] thr_q;
    logic        txen_q;
    logic        up_q;
    logic [3:0]  allow_q;
    wire  [7:0]  f_w = 8'(partner_free);
    wire         act_w = txen_q & partner_tx_ctrl_ok;
    wire         p2_w = f_w >= thr_q[7:0];
    wire         p1_w = p2_w && f_w >= thr_q[15:8];
    wire         p0_w = p1_w && f_w >= thr_q[23:16];
    wire  [3:0]  allow_w = act_w ? {f_w != 0, p2_w, p1_w, p0_w} : 4'hf;
    wire         gen_wr_w = wr_en && addr == endpoint_cfg_pkg::GEN_CTRL_OFS;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            thr_q   <= {endpoint_cfg_pkg::THR_LOW_RST, endpoint_cfg_pkg::THR_MED_RST,
                        endpoint_cfg_pkg::THR_HIGH_RST};
            txen_q  <= endpoint_cfg_pkg::FLOW_TX_EN_RST;
            up_q    <= 1'b0;
            allow_q <= 4'hf;
        end else begin
            up_q    <= 1'b1;
            allow_q <= allow_w;
            if (wr_en && addr == endpoint_cfg_pkg::THRESHOLDS_OFS) thr_q <= wr_data[23:0];
            if (wr_en && addr == endpoint_cfg_pkg::FLOW_CTRL_OFS) txen_q <= wr_data[0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_acked;
        symbol_acked && !symbol_sent ##1 !symbol_sent [*3];
    endsequence

    AST_PRIO3: assert property (up_q |-> prio_allowed_q[3] == allow_q[3])
        else $error("priority 3 gate wrong");
    AST_PRIO2: assert property (up_q |-> prio_allowed_q[2] == allow_q[2])
        else $error("priority 2 gate wrong");
    AST_PRIO1: assert property (up_q |-> prio_allowed_q[1] == allow_q[1])
        else $error("priority 1 gate wrong");
    AST_PRIO0: assert property (up_q |-> prio_allowed_q[0] == allow_q[0])
        else $error("priority 0 gate wrong");
    AST_OPEN: assert property (up_q && !act_w |=> prio_allowed_q == 4'hf)
        else $error("gate closed without transmitter control");
    AST_DECIDE: assert property (pkt_req.valid |=>
        pkt_ans_q.grant == prio_allowed_q[$past(pkt_req.prio)] && pkt_ans_q.grant != pkt_ans_q.hold)
        else $error("packet decision wrong");
    AST_QUIET: assert property (!pkt_req.valid |=> pkt_ans_q == '0)
        else $error("answer without request");
    AST_ID: assert property (rd_en && addr == '0 |=> rd_data_q == {DEVICE_ID, VENDOR_ID})
        else $error("identity read wrong");
    AST_REQ_EN: assert property (gen_wr_w |=> request_enable_q == $past(wr_data[30]))
        else $error("request enable not written");
    AST_REQ_HOLD: assert property (!gen_wr_w |=> $stable(request_enable_q))
        else $error("request enable changed alone");
    AST_LINK_QUIET: assert property (s_acked |-> !link_recover_q)
        else $error("recovery after answered symbol");
endmodule

bind endpoint_flow_gate_and_config_regs endpoint_flow_gate_chk #(
    .ADDR_W(ADDR_W), .FREE_W(FREE_W), .DEVICE_ID(DEVICE_ID), .VENDOR_ID(VENDOR_ID)
) u_chk (
    .*
);
`default_nettype wire

// >>> test/link_partner_model.sv
`timescale 1ns/10ps
`default_nettype none
module link_partner_model #(
    parameter int FREE_W = 8
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [FREE_W-1:0] free_cmd,
    input  wire logic              tx_ok_cmd,
    input  wire logic [3:0]        ack_wait,
    input  wire logic              symbol_sent,
    output logic [FREE_W-1:0]      partner_free,
    output logic                   partner_tx_ctrl_ok,
    output logic                   symbol_acked
);
    logic [3:0] cnt_q;

    // A zero wait models a partner that never answers a control symbol
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            partner_free       <= '0;
            partner_tx_ctrl_ok <= 1'b0;
            symbol_acked       <= 1'b0;
            cnt_q              <= 4'h0;
        end else begin
            partner_free       <= free_cmd;
            partner_tx_ctrl_ok <= tx_ok_cmd;
            symbol_acked       <= !symbol_sent && cnt_q == 4'h1;
            if (symbol_sent) cnt_q <= ack_wait;
            else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> test/endpoint_flow_gate_and_config_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module endpoint_flow_gate_and_config_regs_bench;
    localparam int TICK = 2;
    logic                       clk = 1'b0;
    logic                       resetn = 1'b0;
    logic [15:0]                addr = 16'h0000;
    logic [31:0]                wr_data = 32'h0;
    logic                       wr_en = 1'b0;
    logic                       rd_en = 1'b0;
    logic                       symbol_sent = 1'b0;
    logic                       tx_ok_cmd = 1'b1;
    logic [7:0]                 free_cmd = 8'h00;
    logic [3:0]                 ack_wait = 4'h0;
    endpoint_cfg_pkg::pkt_req_s pkt_req = '0;
    endpoint_cfg_pkg::pkt_ans_s pkt_ans_q;
    logic [31:0]                rd_data_q;
    logic [7:0]                 partner_free;
    logic [3:0]                 prio_allowed_q;
    logic [23:0]                response_timeout_q;
    logic                       partner_tx_ctrl_ok, symbol_acked, link_recover_q;
    logic                       request_enable_q, irq_q;
    int                         n_mismatch = 0;
    int                         compares = 0;

    always #5 clk = ~clk;

    endpoint_flow_gate_and_config_regs #(
        .TICK_CYCLES(TICK),
        .DEVICE_ID  (16'h5a5a), // Arbitrary value
        .VENDOR_ID  (16'h0c3c), // Arbitrary value
        .ASM_ID     (16'h1111),
        .ASM_VENDOR (16'h2222),
        .ASM_REV    (16'h0033)
    ) DUT (
        .*
    );

    link_partner_model PARTNER (
        .*
    );

    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 check(rd_data_q, exp);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1 check(32'(irq_q), 32'(e));
    endtask

    function automatic logic [3:0] want(input int f);
        return {f > 0, f >= 2, f >= 4, f >= 6};
    endfunction

    task automatic gate(input int f, input logic ok, input logic [3:0] exp);
        @(posedge clk);
        free_cmd  <= 8'(f);
        tx_ok_cmd <= ok;
        repeat (2) @(posedge clk);
        for (int p = 0; p < 5; p++) begin
            @(posedge clk);
            pkt_req.valid <= p < 4;
            pkt_req.prio  <= 2'(p);
            #1;
            if (p > 0) check(32'(pkt_ans_q), {30'h0, exp[p-1], !exp[p-1]});
        end
        check(32'(prio_allowed_q), 32'(exp));
    endtask

    task automatic probe(input logic [3:0] w, input int lo, input int hi);
        int n;
        n = 0;
        @(posedge clk);
        ack_wait    <= w;
        symbol_sent <= 1'b1;
        @(posedge clk);
        symbol_sent <= 1'b0;
        while (n < 40 && link_recover_q !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        check(32'(n >= lo && n <= hi), 32'h1);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(16'h013c, 32'he0000000);
        check(32'(request_enable_q), 32'h1);
        check(32'(response_timeout_q), 32'h00ffffff);
        rd(16'h0000, 32'h5a5a0c3c);
        wr(16'h0000, 32'hffffffff);
        rd(16'h0000, 32'h5a5a0c3c);
        rd(16'h0008, 32'h11112222);
        rd(16'h000c, 32'h00330100);
        rd(16'h0010, 32'h40000008);
        rd(16'h0100, 32'h04000001);
        rd(16'h0400, 32'h0000000d);
        wr(16'h0200, 32'hffffffff);
        rd(16'h0200, 32'h0);
        wr(16'h013c, 32'h0);
        check(32'(request_enable_q), 32'h0);
        wr(16'h013c, 32'ha0000000);
        rd(16'h013c, 32'ha0000000);
        check(32'(request_enable_q), 32'h0);
        wr(16'h013c, 32'h40000000);
        check(32'(request_enable_q), 32'h1);
        wr(16'h0124, 32'h12345600);
        check(32'(response_timeout_q), 32'h00123456);
        wr(16'h0040, 32'h00060402);
        rd(16'h0040, 32'h00060402);
        for (int f = 0; f < 8; f++) gate(f, 1'b1, want(f));
        irq_is(1'b0);
        rd(16'h0048, 32'h2);
        wr(16'h004c, 32'h7);
        irq_is(1'b1);
        wr(16'h0048, 32'h2);
        irq_is(1'b0);
        gate(0, 1'b0, 4'hf);
        rd(16'h0048, 32'h4);
        wr(16'h0048, 32'h4);
        wr(16'h0044, 32'h0);
        gate(0, 1'b1, 4'hf);
        rd(16'h0044, 32'hf0);
        wr(16'h0044, 32'h1);
        wr(16'h0120, 32'h100);
        probe(4'h2, 40, 40);
        probe(4'h0, 2 * TICK + 1, 2 * TICK + 4);
        rd(16'h0048, 32'h1);
        irq_is(1'b1);
        wr(16'h0048, 32'h1);
        wr(16'h0120, 32'h700);
        probe(4'h0, 8 * TICK + 1, 8 * TICK + 4);
        close_out();
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule
`default_nettype wire
